// ==== hdl/poc_consts.vh ====
`ifndef POC_CONSTS_VH
`define POC_CONSTS_VH
// Parallel output width and top line positions
`define POC_LINES        25
`define POC_TOP_BIT      24
`define POC_SUB_BIT      23
// Output source selection
`define POC_SRC_FIXED_MIN 3'd3
`define POC_FMT_BIN      2'd0
`define POC_FMT_GRAY     2'd1
`define POC_FMT_BCD      2'd2
// Fixed test value reset and update interval in ms
`define POC_TEST_RESET   25'h000_0000
`define POC_UPD_MIN_MS   14'd1
`define POC_UPD_MAX_MS   14'd9999
`define POC_UPD_DEF_MS   14'd10
// Cycles per millisecond at 10 MHz (1 ms / 100 ns)
`define POC_CLK_PERIOD_NS 100
`define POC_MS_NS         1000000
`define POC_CYC_PER_MS    (`POC_MS_NS / `POC_CLK_PERIOD_NS)
// Factory restore hold time in ms
`define POC_FACT_HOLD_MS  1000
// Trigger configuration codes
`define POC_TRIG_LOW     2'd0
`define POC_TRIG_HIGH    2'd1
`define POC_TRIG_RISE    2'd2
`define POC_TRIG_FALL    2'd3
// Command codes
`define POC_CMD_SET      4'd1
`define POC_CMD_FREEZE   4'd2
`define POC_CMD_ZERO     4'd3
`define POC_CMD_SET_A    4'd4
`define POC_CMD_SET_B    4'd5
`define POC_CMD_LOCK_A   4'd6
`define POC_CMD_LOCK_B   4'd7
`define POC_CMD_MINMAX   4'd8
`define POC_CMD_FACTORY  4'd9
// Operating modes
`define POC_MODE_COUNTER 2'd1
`define POC_MODE_ENCODER 2'd2
`define POC_MODE_STSP    2'd3
`endif

// ==== hdl/poc_trigger.v ====
`timescale 1ns/1ps
`include "poc_consts.vh"
module poc_trigger (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Pin and configuration
  input  wire       pin_in,
  input  wire [1:0] trig_cfg,
  // Detected activity
  output wire       active,
  output wire       pulse
);
  reg s1_q;
  reg s2_q;
  reg prev_q;

  // ****************************************
  // Synchroniser and edge history
  // ****************************************
  // Two stages before anything looks at the pin
  always @(posedge clk) begin
    if (reset) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      s1_q   <= pin_in;
      s2_q   <= s1_q;
      prev_q <= s2_q;
    end
  end

  // Level triggers hold active, edges give one cycle
  assign active = (trig_cfg == `POC_TRIG_LOW)  ? ~s2_q :
                  (trig_cfg == `POC_TRIG_HIGH) ?  s2_q :
                  pulse;
  assign pulse  = (trig_cfg == `POC_TRIG_RISE) ? (s2_q & ~prev_q) :
                  (trig_cfg == `POC_TRIG_FALL) ? (~s2_q & prev_q) :
                  1'b0;
endmodule // poc_trigger

// ==== hdl/poc_encode.v ====
`timescale 1ns/1ps
`include "poc_consts.vh"
module poc_encode (
  // Value and format
  input  wire [24:0] value,
  input  wire [1:0]  fmt,
  // Encoded word
  output reg  [24:0] coded
);
  integer i;
  reg [24:0] rem;
  reg [27:0] bcd;

  // ****************************************
  // Format conversion
  // ****************************************
  // BCD by shift-and-add; magnitude only, upper digits clip to 25 lines
  always @* begin
    rem = value;
    bcd = 28'h000_0000;
    coded = value;
    for (i = 24; i >= 0; i = i - 1) begin
      if (bcd[3:0]   > 4'd4) bcd[3:0]   = bcd[3:0]   + 4'd3;
      if (bcd[7:4]   > 4'd4) bcd[7:4]   = bcd[7:4]   + 4'd3;
      if (bcd[11:8]  > 4'd4) bcd[11:8]  = bcd[11:8]  + 4'd3;
      if (bcd[15:12] > 4'd4) bcd[15:12] = bcd[15:12] + 4'd3;
      if (bcd[19:16] > 4'd4) bcd[19:16] = bcd[19:16] + 4'd3;
      if (bcd[23:20] > 4'd4) bcd[23:20] = bcd[23:20] + 4'd3;
      bcd = {bcd[26:0], rem[i]};
    end
    case (fmt)
      `POC_FMT_GRAY: coded = value ^ {1'b0, value[24:1]};
      `POC_FMT_BCD:  coded = bcd[24:0];
      default:       coded = value;
    endcase
  end
endmodule // poc_encode

// ==== hdl/poc_parallel_out.v ====
`timescale 1ns/1ps
`include "poc_consts.vh"
// Contract
// - Inversion drives logic 0 high, 1 low
// - Source above 2 outputs fixed test value
// - Test value signed 25 bit, default zero
// - Refresh interval 1 to 9999 ms, default 10
// - Role 0: top lines are data bits
// - Roles 1-3: error flag variants on top
// - Roles 4-6: data-stable, error flag variants
// - Roles 7-10: stable plus error or stable pairs
// - Trigger codes: low, high, rising, falling
// - Level commands hold; edge commands act once
// - Cmd 1 encoder: position into display offset
// - Cmd 1 counter: preset both channels
// - Cmd 1 start/stop: store offset nonvolatile
// - Cmd 2 freezes result and output
// - Cmd 3 encoder: position into zero shift
// - Cmds 4,5 preset channel A or B
// - Cmds 6,7 lock channel A or B
// - Cmd 8 clears min/max tracking
// - Cmd 9 factory restore after one second hold
// - Input two uses same codes as one
// - Input three fixed factory restore, rising
// - Source code picks binary, Gray or BCD
// - No inversion drives logic 1 high
module poc_parallel_out #(
  parameter FACT_HOLD_CYC = `POC_FACT_HOLD_MS * `POC_CYC_PER_MS,
  parameter MS_CYC        = `POC_CYC_PER_MS
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Measurement and status
  input  wire [24:0] meas_result,
  input  wire        meas_error,
  input  wire [1:0]  op_mode,
  input  wire [31:0] encoder_position,
  input  wire [31:0] stsp_position,
  // Output configuration
  input  wire [2:0]  output_source_select,
  input  wire        output_polarity_invert,
  input  wire [3:0]  top_line_role_select,
  input  wire [13:0] update_interval_ms,
  // Test value write over serial access
  input  wire        test_value_we,
  input  wire [24:0] test_value_wdata,
  // Control inputs and configuration
  input  wire        ctrl_pin_one,
  input  wire        ctrl_pin_two,
  input  wire        ctrl_pin_three,
  input  wire [3:0]  ctrl_input_one_command,
  input  wire [1:0]  ctrl_input_one_trigger,
  input  wire [3:0]  ctrl_input_two_command,
  input  wire [1:0]  ctrl_input_two_trigger,
  // Parallel lines
  output reg  [24:0] parallel_lines,
  output reg         data_stable,
  output wire [24:0] test_value,
  // Command actions
  output reg         display_offset_load,
  output reg  [31:0] display_offset_param,
  output reg         encoder_zero_capture_cmd,
  output reg  [31:0] encoder_zero_shift_param,
  output wire        preset_a,
  output wire        preset_b,
  output wire        lock_a,
  output wire        lock_b,
  output wire        nv_offset_store,
  output wire        minmax_clear,
  output wire        freeze_active,
  output reg         factory_restore
);
  reg  [24:0] test_q;
  reg  [31:0] ms_cnt_q;
  reg  [13:0] int_cnt_q;
  reg  [24:0] frozen_q;
  reg  [31:0] fact_cnt_q;
  reg         p3_s1_q;
  reg         p3_s2_q;
  wire        act1;
  wire        act2;
  wire        act3;
  wire        pls3;
  wire [24:0] src_val;
  wire [24:0] coded;
  wire [13:0] interval;
  wire        tick;
  reg  [24:0] lines_d;

  // ****************************************
  // Command decode helper
  // ****************************************
  // True when either programmable input asserts the given command
  function cmd_hit;
    input [3:0] cmd;
    input [3:0] c1;
    input       a1;
    input [3:0] c2;
    input       a2;
    begin
      cmd_hit = (a1 && c1 == cmd) || (a2 && c2 == cmd);
    end
  endfunction

  // ****************************************
  // Control inputs
  // ****************************************
  poc_trigger u_trig_one (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (ctrl_pin_one),
    .trig_cfg (ctrl_input_one_trigger),
    .active   (act1),
    .pulse    ()
  );
  // Second input shares the same code tables
  poc_trigger u_trig_two (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (ctrl_pin_two),
    .trig_cfg (ctrl_input_two_trigger),
    .active   (act2),
    .pulse    ()
  );
  // Third input is hard wired to rising edge
  poc_trigger u_trig_three (
    .clk      (clk),
    .reset    (reset),
    .pin_in   (ctrl_pin_three),
    .trig_cfg (`POC_TRIG_RISE),
    .active   (act3),
    .pulse    (pls3)
  );

  // Command effects; caller pairs level/edge as configured
  assign freeze_active = cmd_hit(`POC_CMD_FREEZE, ctrl_input_one_command, act1,
                                 ctrl_input_two_command, act2);
  assign preset_a = (op_mode == `POC_MODE_COUNTER) &&
                    (cmd_hit(`POC_CMD_SET, ctrl_input_one_command, act1,
                             ctrl_input_two_command, act2) ||
                     cmd_hit(`POC_CMD_SET_A, ctrl_input_one_command, act1,
                             ctrl_input_two_command, act2));
  assign preset_b = (op_mode == `POC_MODE_COUNTER) &&
                    (cmd_hit(`POC_CMD_SET, ctrl_input_one_command, act1,
                             ctrl_input_two_command, act2) ||
                     cmd_hit(`POC_CMD_SET_B, ctrl_input_one_command, act1,
                             ctrl_input_two_command, act2));
  assign lock_a = (op_mode == `POC_MODE_COUNTER) &&
                  cmd_hit(`POC_CMD_LOCK_A, ctrl_input_one_command, act1,
                          ctrl_input_two_command, act2);
  assign lock_b = (op_mode == `POC_MODE_COUNTER) &&
                  cmd_hit(`POC_CMD_LOCK_B, ctrl_input_one_command, act1,
                          ctrl_input_two_command, act2);
  assign nv_offset_store = (op_mode == `POC_MODE_STSP) &&
                           cmd_hit(`POC_CMD_SET, ctrl_input_one_command, act1,
                                   ctrl_input_two_command, act2);
  assign minmax_clear = cmd_hit(`POC_CMD_MINMAX, ctrl_input_one_command, act1,
                                ctrl_input_two_command, act2);

  // ****************************************
  // Encoder offset captures
  // ****************************************
  // Position arrives already bit-suppressed and zero-shifted
  always @(posedge clk) begin
    if (reset) begin
      display_offset_load      <= 1'b0;
      display_offset_param     <= 32'h0000_0000;
      encoder_zero_capture_cmd <= 1'b0;
      encoder_zero_shift_param <= 32'h0000_0000;
    end else begin
      display_offset_load      <= 1'b0;
      encoder_zero_capture_cmd <= 1'b0;
      if (op_mode == `POC_MODE_ENCODER &&
          cmd_hit(`POC_CMD_SET, ctrl_input_one_command, act1,
                  ctrl_input_two_command, act2)) begin
        display_offset_load  <= 1'b1;
        display_offset_param <= encoder_position;
      end
      if (op_mode == `POC_MODE_ENCODER &&
          cmd_hit(`POC_CMD_ZERO, ctrl_input_one_command, act1,
                  ctrl_input_two_command, act2)) begin
        encoder_zero_capture_cmd <= 1'b1;
        encoder_zero_shift_param <= encoder_position;
      end
    end
  end

  // ****************************************
  // Factory restore hold timer
  // ****************************************
  // Programmable inputs need a held level; input three arms on its edge
  // and must then stay high, so a bounce restarts the wait
  always @(posedge clk) begin
    if (reset) begin
      fact_cnt_q      <= 32'h0000_0000;
      factory_restore <= 1'b0;
    end else begin
      factory_restore <= 1'b0;
      if (cmd_hit(`POC_CMD_FACTORY, ctrl_input_one_command, act1,
                  ctrl_input_two_command, act2) ||
          pls3 || (fact_cnt_q != 32'h0000_0000 && p3_s2_q)) begin
        if (fact_cnt_q == FACT_HOLD_CYC - 1) begin
          factory_restore <= 1'b1;
          fact_cnt_q      <= fact_cnt_q;
        end else begin
          fact_cnt_q <= fact_cnt_q + 32'h0000_0001;
        end
      end else begin
        fact_cnt_q <= 32'h0000_0000;
      end
    end
  end

  // Third input held level through its own two stages
  // Kept local so no logic reaches into the trigger instance
  always @(posedge clk) begin
    if (reset) begin
      p3_s1_q <= 1'b0;
      p3_s2_q <= 1'b0;
    end else begin
      p3_s1_q <= ctrl_pin_three;
      p3_s2_q <= p3_s1_q;
    end
  end

  // ****************************************
  // Fixed test value
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      test_q <= `POC_TEST_RESET;
    end else if (test_value_we) begin
      test_q <= test_value_wdata;
    end
  end
  assign test_value = test_q;

  // ****************************************
  // Refresh timer
  // ****************************************
  // Out-of-range intervals clamp rather than stall the output
  assign interval = (update_interval_ms < `POC_UPD_MIN_MS) ? `POC_UPD_MIN_MS :
                    (update_interval_ms > `POC_UPD_MAX_MS) ? `POC_UPD_MAX_MS :
                    update_interval_ms;
  assign tick = (ms_cnt_q == MS_CYC - 1) && (int_cnt_q == interval - 14'd1);
  always @(posedge clk) begin
    if (reset) begin
      ms_cnt_q  <= 32'h0000_0000;
      int_cnt_q <= 14'h0000;
    end else if (ms_cnt_q == MS_CYC - 1) begin
      ms_cnt_q  <= 32'h0000_0000;
      int_cnt_q <= (int_cnt_q >= interval - 14'd1) ? 14'h0000 :
                   int_cnt_q + 14'd1;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
    end
  end

  // ****************************************
  // Source, format and freeze
  // ****************************************
  always @(posedge clk) begin
    if (reset) begin
      frozen_q <= 25'h000_0000;
    end else if (!freeze_active) begin
      frozen_q <= meas_result;
    end
  end
  assign src_val = (output_source_select >= `POC_SRC_FIXED_MIN) ? test_q :
                   frozen_q;

  poc_encode u_encode (
    .value (src_val),
    .fmt   ((output_source_select >= `POC_SRC_FIXED_MIN) ?
            output_source_select[1:0] - 2'd3 + 2'd0 :
            output_source_select[1:0]),
    .coded (coded)
  );

  // ****************************************
  // Top line roles and polarity
  // ****************************************
  // Flags take the stable state about to be shown
  always @* begin
    lines_d = coded ^ {25{output_polarity_invert}};
    case (top_line_role_select)
      4'd1: lines_d[24] = meas_error;
      4'd2: lines_d[24] = ~meas_error;
      4'd3: lines_d[24:23] = {meas_error, ~meas_error};
      4'd4: lines_d[24] = 1'b1;
      4'd5: lines_d[24] = 1'b0;
      4'd6: lines_d[24:23] = {1'b1, meas_error};
      4'd7: lines_d[24:23] = {1'b1, ~meas_error};
      4'd8: lines_d[24:23] = {1'b0, meas_error};
      4'd9: lines_d[24:23] = {1'b0, ~meas_error};
      4'd10: lines_d[24:23] = {1'b1, 1'b0};
      default: lines_d = lines_d;
    endcase
  end

  // ****************************************
  // Output register
  // ****************************************
  // Stable drops one cycle at each refresh so the reader sees the change
  always @(posedge clk) begin
    if (reset) begin
      parallel_lines <= 25'h000_0000 ^ {25{1'b0}};
      data_stable    <= 1'b0;
    end else if (tick && !freeze_active) begin
      parallel_lines <= lines_d;
      data_stable    <= 1'b0;
    end else begin
      parallel_lines <= parallel_lines;
      data_stable    <= 1'b1;
    end
  end
endmodule // poc_parallel_out

// ==== tb/poc_parallel_out_checker.sv ====
`timescale 1ns/1ps
module poc_parallel_out_checker #(
  parameter FACT_HOLD_CYC = 20,
  parameter MS_CYC        = 4
) (
  // Clock and reset
  input wire        clk,
  input wire        reset,
  // Watched inputs
  input wire        meas_error,
  input wire [1:0]  op_mode,
  input wire [2:0]  output_source_select,
  input wire        output_polarity_invert,
  input wire [3:0]  top_line_role_select,
  input wire        test_value_we,
  input wire [24:0] test_value_wdata,
  input wire        ctrl_pin_one,
  input wire        ctrl_pin_three,
  input wire [3:0]  ctrl_input_one_command,
  input wire [1:0]  ctrl_input_one_trigger,
  input wire [3:0]  ctrl_input_two_command,
  // Watched outputs
  input wire [24:0] parallel_lines,
  input wire        data_stable,
  input wire [24:0] test_value,
  input wire        preset_a,
  input wire        minmax_clear,
  input wire        freeze_active,
  input wire        factory_restore
);
  // Consecutive cycles with input three high, saturating
  reg [31:0] hold_q;
  always @(posedge clk) begin
    if (reset || !ctrl_pin_three) hold_q <= 32'h0000_0000;
    else if (hold_q != 32'hffff_ffff) hold_q <= hold_q + 32'h0000_0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************
  // Sequences and properties
  // ****************************************
  sequence s_load; $fell(data_stable); endsequence
  sequence s_min_held;
    (ctrl_pin_one && ctrl_input_one_command == 4'h8 && ctrl_input_one_trigger == 2'h1
     && ctrl_input_two_command == 4'h0)[*4];
  endsequence
  property p_stable_pulse; s_load |=> data_stable; endproperty
  property p_hold; data_stable && !$past(reset) |-> $stable(parallel_lines); endproperty
  property p_tv_default; $fell(reset) |-> test_value == 25'h000_0000; endproperty
  property p_tv_write; test_value_we |=> test_value == $past(test_value_wdata); endproperty
  property p_invert;
    s_load ##0 ($past(top_line_role_select) == 4'h0 && $past(output_source_select) == 3'h3
      && $past(output_polarity_invert)) |-> parallel_lines == ~$past(test_value);
  endproperty
  property p_err_top;
    s_load ##0 ($past(top_line_role_select) == 4'h1 && $past(meas_error) == $past(meas_error, 2))
      |-> parallel_lines[24] == $past(meas_error);
  endproperty
  property p_pair;
    s_load ##0 ($past(top_line_role_select) == 4'h3 || $past(top_line_role_select) == 4'ha)
      |-> parallel_lines[24] != parallel_lines[23];
  endproperty
  property p_freeze; freeze_active && $past(freeze_active) |-> $stable(parallel_lines); endproperty
  property p_edge_once;
    preset_a && ctrl_input_one_trigger == 2'h2 && $stable(ctrl_input_one_trigger)
      && ctrl_input_two_command == 4'h0 |=> !preset_a;
  endproperty
  property p_refuse; preset_a |-> op_mode == 2'h1; endproperty
  property p_level; s_min_held |-> minmax_clear; endproperty
  property p_fact_hold;
    $rose(factory_restore) && ctrl_input_one_command != 4'h9 && ctrl_input_two_command != 4'h9
      |-> hold_q >= FACT_HOLD_CYC;
  endproperty
  a_stable_pulse: assert property (p_stable_pulse) else $error("stable flag low too long");
  a_hold: assert property (p_hold) else $error("lines moved while stable");
  a_tv_default: assert property (p_tv_default) else $error("test value not zero");
  a_tv_write: assert property (p_tv_write) else $error("test value not written");
  a_invert: assert property (p_invert) else $error("inverted word wrong");
  a_err_top: assert property (p_err_top) else $error("top error line wrong");
  a_pair: assert property (p_pair) else $error("top pair not opposite");
  a_freeze: assert property (p_freeze) else $error("lines moved in freeze");
  a_edge_once: assert property (p_edge_once) else $error("edge pulse too long");
  a_refuse: assert property (p_refuse) else $error("preset outside counter mode");
  a_level: assert property (p_level) else $error("level command not acting");
  a_fact_hold: assert property (p_fact_hold) else $error("restore before hold");
endmodule // poc_parallel_out_checker
bind poc_parallel_out poc_parallel_out_checker #(.FACT_HOLD_CYC(FACT_HOLD_CYC), .MS_CYC(MS_CYC))
  u_chk (.clk(clk), .reset(reset), .meas_error(meas_error), .op_mode(op_mode),
  .output_source_select(output_source_select), .output_polarity_invert(output_polarity_invert),
  .top_line_role_select(top_line_role_select), .test_value_we(test_value_we),
  .test_value_wdata(test_value_wdata), .ctrl_pin_one(ctrl_pin_one),
  .ctrl_pin_three(ctrl_pin_three), .ctrl_input_one_command(ctrl_input_one_command),
  .ctrl_input_one_trigger(ctrl_input_one_trigger),
  .ctrl_input_two_command(ctrl_input_two_command), .parallel_lines(parallel_lines),
  .data_stable(data_stable), .test_value(test_value), .preset_a(preset_a),
  .minmax_clear(minmax_clear), .freeze_active(freeze_active),
  .factory_restore(factory_restore));

// ==== tb/poc_plc_model.sv ====
`timescale 1ns/1ps
module poc_plc_model (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Parallel lines as the reader sees them
  input  wire [24:0] lines,
  input  wire        stable,
  // Last settled word and number of reads
  output reg  [24:0] word_q,
  output reg  [15:0] loads_q
);
  reg prev_q;
  // Read only once the flag says the word has settled
  always @(posedge clk) begin
    prev_q <= stable;
    if (reset) begin
      word_q  <= 25'h000_0000;
      loads_q <= 16'h0000;
    end else if (stable && !prev_q) begin
      word_q  <= lines;
      loads_q <= loads_q + 16'h0001;
    end
  end
endmodule // poc_plc_model

// ==== tb/test_poc_parallel_out.sv ====
`timescale 1ns/1ps
module test_poc_parallel_out;
  localparam MS = 4;
  reg clk = 0, reset = 1, err = 0, inv = 0, we = 0, p1 = 0, p2 = 0, p3 = 0, clr = 0;
  reg [24:0] meas = 25'd5678, wd = 0, w0;
  reg [1:0] mode = 0, t1 = 0, t2 = 0;
  reg [2:0] src = 3'h3;
  reg [3:0] role = 0, c1 = 0, c2 = 0;
  reg [13:0] ivl = 14'h0001;
  logic [13:0] ivls [3] = '{14'h0001, 14'h0003, 14'h0000};
  reg [31:0] pos = 32'h0000_1234;
  wire [24:0] lines, tv, word;
  wire [31:0] dop, ezp;
  wire [15:0] loads;
  wire ds, dol, ezc, pa, pb, la, lb, nv, mm, fz, fr;
  int mismatches = 0, checked = 0, n[7], i, r, e, c;
  poc_parallel_out #(.FACT_HOLD_CYC(20), .MS_CYC(MS)) uut (.clk(clk), .reset(reset),
    .meas_result(meas), .meas_error(err), .op_mode(mode), .encoder_position(pos),
    .stsp_position(pos), .output_source_select(src), .output_polarity_invert(inv),
    .top_line_role_select(role), .update_interval_ms(ivl), .test_value_we(we),
    .test_value_wdata(wd), .ctrl_pin_one(p1), .ctrl_pin_two(p2), .ctrl_pin_three(p3),
    .ctrl_input_one_command(c1), .ctrl_input_one_trigger(t1), .ctrl_input_two_command(c2),
    .ctrl_input_two_trigger(t2), .parallel_lines(lines), .data_stable(ds), .test_value(tv),
    .display_offset_load(dol), .display_offset_param(dop), .encoder_zero_capture_cmd(ezc),
    .encoder_zero_shift_param(ezp), .preset_a(pa), .preset_b(pb), .lock_a(la), .lock_b(lb),
    .nv_offset_store(nv), .minmax_clear(mm), .freeze_active(fz), .factory_restore(fr));
  poc_plc_model plc (.clk(clk), .reset(reset), .lines(lines), .stable(ds), .word_q(word),
    .loads_q(loads));
  // Clock, 100 ns period
  initial forever #50 clk = ~clk;
  wire [6:0] cmd_outs = {fr, nv, ezc, dol, mm, pb, pa};
  // Count cycles that pa, pb, mm, dol, ezc, nv and fr are high
  always @(posedge clk) begin
    for (int k = 0; k < 7; k++) n[k] <= clr ? 0 : n[k] + (cmd_outs[k] === 1'b1);
  end
  // ****************************************
  // Tasks
  // ****************************************
  task close_out();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk_v(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_n(input int got, input int exp);
    checked++;
    if (got != exp) begin
      mismatches++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Two reads by the reader, so the word reflects the new setup
  task refresh();
    int s;
    s = loads;
    for (int k = 0; k < 300 && loads < s + 2; k++) begin
      @(posedge clk);
      #1;
    end
    if (loads < s + 2) begin
      mismatches++;
      close_out();
    end
  endtask
  task write_tv(input logic [24:0] v);
    @(posedge clk);
    we <= 1;
    wd <= v;
    @(posedge clk);
    we <= 0;
  endtask
  // Pulse one control pin and count the chosen output
  task cmd_case(input logic [1:0] m, input int sel, input logic [3:0] cm, input logic [1:0] t,
                input int idx, input int len, input int exp);
    @(posedge clk);
    mode <= m;
    c1 <= (sel == 1) ? cm : 4'h0;
    t1 <= t;
    c2 <= (sel == 2) ? cm : 4'h0;
    t2 <= t;
    step(4);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    if (sel == 1) p1 <= 1; else p2 <= 1;
    step(len);
    if (sel == 1) p1 <= 0; else p2 <= 0;
    step(8);
    #1 chk_n(n[idx], exp);
  endtask
  function automatic logic [24:0] exp_word(input int rl, input logic er, input logic [24:0] v,
                                           input logic iv);
    logic [24:0] d;
    d = iv ? ~v : v;
    case (rl)
      1: d[24] = er;
      2: d[24] = ~er;
      3: d[24:23] = {er, ~er};
      4: d[24] = 1'b1;
      5: d[24] = 1'b0;
      6: d[24:23] = {1'b1, er};
      7: d[24:23] = {1'b1, ~er};
      8: d[24:23] = {1'b0, er};
      9: d[24:23] = {1'b0, ~er};
      10: d[24:23] = 2'b10;
      default: ;
    endcase
    return d;
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    step(8);
    reset <= 0;
    #1 chk_v(tv, 0);
    for (i = 0; i < 6; i++) begin
      write_tv(i < 2 ? 25'h100_0000 : i < 4 ? 25'h0ff_ffff : 25'h0ab_cdef);
      inv <= i[0];
      refresh();
      chk_v(lines, exp_word(0, 0, wd, inv));
      chk_v(word, exp_word(0, 0, wd, inv));
    end
    for (e = 0; e < 2; e++) for (r = 1; r < 11; r++) begin
      step(1);
      err <= e[0];
      role <= r[3:0];
      refresh();
      chk_v(lines, exp_word(r, e[0], wd, inv));
    end
    step(1);
    role <= 0;
    inv <= 0;
    write_tv(25'd1234);
    for (i = 0; i < 6; i++) begin
      step(1);
      src <= i[2:0];
      refresh();
      w0 = (i < 3) ? 25'd5678 : 25'd1234;
      chk_v(lines, i % 3 == 0 ? w0 : i % 3 == 1 ? w0 ^ (w0 >> 1) :
            (i < 3 ? 25'h000_5678 : 25'h000_1234));
    end
    foreach (ivls[j]) begin
      step(1);
      ivl <= ivls[j];
      refresh();
      e = loads;
      for (c = 0; c < 100 && loads == e; c++) begin
        @(posedge clk);
        #1;
      end
      chk_n(c, MS * (j == 1 ? 3 : 1));
    end
    step(1);
    c1 <= 4'h2;
    t1 <= 2'h1;
    p1 <= 1;
    step(4);
    #1 chk_v(fz, 1);
    w0 = lines;
    write_tv(25'h000_0077);
    step(20);
    #1 chk_v(lines, w0);
    step(1);
    p1 <= 0;
    refresh();
    chk_v(lines, 25'h000_0119);
    cmd_case(1, 1, 4'h4, 2'h2, 0, 5, 1);
    cmd_case(1, 1, 4'h5, 2'h3, 1, 5, 1);
    cmd_case(2, 1, 4'h4, 2'h2, 0, 5, 0);
    cmd_case(1, 1, 4'h1, 2'h2, 0, 5, 1);
    chk_n(n[1], 1);
    cmd_case(0, 2, 4'h8, 2'h2, 2, 5, 1);
    cmd_case(0, 1, 4'h8, 2'h1, 2, 6, 6);
    cmd_case(2, 1, 4'h1, 2'h2, 3, 5, 1);
    chk_v(dop, pos);
    step(1);
    pos <= 32'h0000_4321;
    cmd_case(2, 2, 4'h3, 2'h2, 4, 5, 1);
    chk_v(ezp, 32'h0000_4321);
    cmd_case(3, 1, 4'h1, 2'h2, 5, 5, 1);
    cmd_case(1, 2, 4'h6, 2'h1, 0, 1, 0);
    step(1);
    p2 <= 1;
    step(4);
    #1 chk_v({la, lb}, 2'b10);
    step(1);
    c2 <= 4'h7;
    t2 <= 2'h0;
    step(4);
    #1 chk_v({la, lb}, 2'b00);
    step(1);
    p2 <= 0;
    step(4);
    #1 chk_v({la, lb}, 2'b01);
    cmd_case(0, 1, 4'h0, 2'h1, 6, 1, 0);
    step(1);
    p3 <= 1;
    step(15);
    p3 <= 0;
    step(6);
    #1 chk_n(n[6], 0);
    step(1);
    p3 <= 1;
    step(40);
    #1 chk_n(n[6] > 0, 1);
    step(1);
    p3 <= 0;
    step(6);
    close_out();
  end
endmodule // test_poc_parallel_out
